// ==== common/pca_pkg.sv ====
// Shared constants for the configuration mechanism host and its bus target
package pca_pkg;

   // ==========================================================================
   // Register offsets and selector fields
   localparam logic [11:0] SEL_OFS    = 12'hcf8;
   localparam logic [11:0] DATA_OFS   = 12'hcfc;
   localparam int          EN_BIT     = 31;
   localparam int          BUS_HI     = 23;
   localparam int          BUS_LO     = 16;
   localparam int          DEV_HI     = 15;
   localparam int          DEV_LO     = 11;
   localparam int          FN_HI      = 10;
   localparam int          FN_LO      = 8;
   localparam int          IDX_HI     = 7;
   localparam int          IDX_LO     = 2;
   localparam logic [31:0] SEL_RESET  = 32'h0000_0000;
   localparam logic [31:0] SEL_WMASK  = 32'h80ff_ffff;
   localparam logic [3:0]  STRB_FULL  = 4'hf;
   localparam logic [1:0]  TYPE0      = 2'h0;
   localparam logic [1:0]  TYPE1      = 2'h1;

   // ==========================================================================
   // Bus commands, idle levels, timing
   localparam logic [3:0]  CMD_IO_RD  = 4'h2;
   localparam logic [3:0]  CMD_IO_WR  = 4'h3;
   localparam logic [3:0]  CMD_CFG_RD = 4'ha;
   localparam logic [3:0]  CMD_CFG_WR = 4'hb;
   localparam logic [3:0]  CBE_IDLE   = 4'hf;
   localparam logic [31:0] ALL_ONES   = 32'hffff_ffff;
   localparam logic [31:0] ZERO_WORD  = 32'h0000_0000;
   localparam int          IDSEL_W    = 21;
   localparam int          IDSEL_DEV0 = 16;
   localparam int          AD_IDSEL_LO = 11;
   localparam logic [2:0]  ABORT_CYCLES = 3'h5;
   localparam int          CLK_PERIOD_NS = 20;

   // ==========================================================================
   // Board device map
   localparam logic [7:0]  BUS_LOCAL   = 8'h00;
   localparam logic [7:0]  BUS_EXP     = 8'h02;
   localparam logic [4:0]  DEV_MEMCTL  = 5'h00;
   localparam logic [4:0]  DEV_GFXBRG  = 5'h01;
   localparam logic [4:0]  DEV_PCIBRG  = 5'h1e;
   localparam logic [4:0]  DEV_IOHUB   = 5'h1f;
   localparam logic [2:0]  IOHUB_FN_MAX = 3'h5;
   localparam logic [4:0]  DEV_NIC     = 5'h08;
   localparam logic [4:0]  DEV_SLOT1   = 5'h04;
   localparam logic [4:0]  DEV_SLOT2   = 5'h09;
   localparam logic [4:0]  DEV_SLOT3   = 5'h0a;
   localparam logic [4:0]  DEV_SLOT4   = 5'h0b;
   localparam logic [4:0]  DEV_SLOT5   = 5'h0d;

   // ==========================================================================
   // Target configuration space
   localparam int          CFG_WORDS   = 64;
   localparam logic [5:0]  IDX_ID      = 6'h00;
   localparam logic [15:0] VENDOR_DFLT = 16'h1234;  // Arbitrary value
   localparam logic [15:0] DEVICE_DFLT = 16'h5678;  // Arbitrary value

endpackage

// ==== common/pca_bus_if.sv ====
// Configuration bus between the host cycle generator and a target
`timescale 1ns/1ns
interface pca_bus_if;
   logic        frame_n;
   logic        irdy_n;
   logic [3:0]  cbe_n;
   logic [31:0] init_ad_o;
   logic        init_ad_oe_n;
   logic        devsel_n;
   logic        trdy_n;
   logic [31:0] tgt_ad_o;
   logic        tgt_ad_oe_n;
   logic [31:0] ad;

   // ==========================================================================
   // Wire level: pulled up when nobody drives
   assign ad = !init_ad_oe_n ? init_ad_o : (!tgt_ad_oe_n ? tgt_ad_o : pca_pkg::ALL_ONES);

   modport initiator (
      output frame_n,
      output irdy_n,
      output cbe_n,
      output init_ad_o,
      output init_ad_oe_n,
      input  devsel_n,
      input  trdy_n,
      input  ad
   );

   modport target (
      input  frame_n,
      input  irdy_n,
      input  cbe_n,
      input  ad,
      output devsel_n,
      output trdy_n,
      output tgt_ad_o,
      output tgt_ad_oe_n
   );
endinterface // pca_bus_if

// ==== logic/pca_idsel_dec.sv ====
// One-hot IDSEL line decode from device numbers 0 to 15
`timescale 1ns/1ns
module pca_idsel_dec (
   input  wire logic [4:0]                 dev,
   output      logic [pca_pkg::IDSEL_W-1:0] idsel
);
   // ==========================================================================
   // Line AD[11+i] selects device 11+i-16; devices above 15 have no line
   genvar i;
   generate
      for (i = 0; i < pca_pkg::IDSEL_W; i++) begin : g_line
         if (i + pca_pkg::AD_IDSEL_LO >= pca_pkg::IDSEL_DEV0) begin : g_used
            assign idsel[i] = (dev == 5'(i + pca_pkg::AD_IDSEL_LO - pca_pkg::IDSEL_DEV0));  // [RULE13] [RULE15]
         end else begin : g_none
            assign idsel[i] = 1'b0;
         end
      end
   endgenerate
endmodule // pca_idsel_dec

// ==== logic/pca_cfg_target.sv ====
// Configuration target, with a bridge path for one device behind it
`timescale 1ns/1ns
module pca_cfg_target #(
   parameter int         IDSEL_AD   = 20,
   parameter logic [7:0] SEC_BUS    = 8'h02,
   parameter logic [4:0] BEHIND_DEV = 5'h08
) (
   input  wire logic       pclk,
   input  wire logic       presetn,
   pca_bus_if.target       bus,
   output      logic       cfg_wr_stb,
   output      logic [5:0] cfg_index
);
   logic [31:0] mem_q [pca_pkg::CFG_WORDS];
   logic        active_q;
   logic        wr_q;
   logic [5:0]  idx_q;
   logic        devsel_n_q;
   logic        trdy_n_q;
   logic [31:0] ad_o_q;
   logic        ad_oe_n_q;
   logic        wr_stb_q;

   // ==========================================================================
   // Address phase decode
   wire       is_cfg = !bus.frame_n && (bus.cbe_n[3:1] == pca_pkg::CMD_CFG_RD[3:1]);
   wire [5:0] idx    = bus.ad[pca_pkg::IDX_HI:pca_pkg::IDX_LO];
   wire       fn0    = (bus.ad[pca_pkg::FN_HI:pca_pkg::FN_LO] == 3'h0);
   wire       t0_hit = is_cfg && (bus.ad[1:0] == pca_pkg::TYPE0) && bus.ad[IDSEL_AD] && fn0;  // [RULE13]
   // Type 1 for our secondary bus is taken as a Type 0 to the device behind
   wire       t1_hit = is_cfg && (bus.ad[1:0] == pca_pkg::TYPE1) && fn0 &&
                       (bus.ad[pca_pkg::BUS_HI:pca_pkg::BUS_LO] == SEC_BUS) &&
                       (bus.ad[pca_pkg::DEV_HI:pca_pkg::DEV_LO] == BEHIND_DEV);  // [RULE12]
   wire       hit    = t0_hit || t1_hit;

   function automatic logic [31:0] word_at(input logic [5:0] i, input logic [31:0] stored);
      word_at = (i == pca_pkg::IDX_ID) ? {pca_pkg::DEVICE_DFLT, pca_pkg::VENDOR_DFLT} : stored;  // [RULE17]
   endfunction

   // ==========================================================================
   // Pins: claim in the first data cycle, release after it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         active_q   <= 1'b0;
         wr_q       <= 1'b0;
         idx_q      <= 6'h00;
         devsel_n_q <= 1'b1;
         trdy_n_q   <= 1'b1;
         ad_o_q     <= pca_pkg::ZERO_WORD;
         ad_oe_n_q  <= 1'b1;
      end else if (hit) begin
         active_q   <= 1'b1;
         wr_q       <= bus.cbe_n[0];
         idx_q      <= idx;
         devsel_n_q <= 1'b0;
         trdy_n_q   <= 1'b0;
         ad_o_q     <= word_at(idx, mem_q[idx]);
         ad_oe_n_q  <= bus.cbe_n[0];
      end else if (active_q && !bus.irdy_n) begin
         active_q   <= 1'b0;
         devsel_n_q <= 1'b1;
         trdy_n_q   <= 1'b1;
         ad_oe_n_q  <= 1'b1;
      end
   end

   // ==========================================================================
   // Configuration space: 256 bytes, identity word read-only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int w = 0; w < pca_pkg::CFG_WORDS; w++) begin
            mem_q[w] <= pca_pkg::ZERO_WORD;
         end
      end else if (active_q && wr_q && !bus.irdy_n && idx_q != pca_pkg::IDX_ID) begin
         for (int b = 0; b < 4; b++) begin
            if (!bus.cbe_n[b]) begin
               mem_q[idx_q][b*8 +: 8] <= bus.ad[b*8 +: 8];  // [RULE14]
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_stb_q <= 1'b0;
      end else begin
         wr_stb_q <= active_q && wr_q && !bus.irdy_n;
      end
   end

   assign bus.devsel_n    = devsel_n_q;
   assign bus.trdy_n      = trdy_n_q;
   assign bus.tgt_ad_o    = ad_o_q;
   assign bus.tgt_ad_oe_n = ad_oe_n_q;
   assign cfg_wr_stb      = wr_stb_q;
   assign cfg_index       = idx_q;
endmodule // pca_cfg_target

// ==== logic/pca_cfg_master.sv ====
// Host side generator of configuration cycles, reached over APB
//
// Operation
// [RULE1] Selector register, bit 31 enables cycles
// [RULE2] Selector takes full 32-bit writes only
// [RULE3] Bits 30..24 reserved, read as zero
// [RULE4] Bits 23..16 give target bus
// [RULE5] Bits 15..11 give device number
// [RULE6] Bits 10..8 give function number
// [RULE7] Bits 7..2 index a dword
// [RULE8] Bits 1..0 choose Type 0 or 1
// [RULE9] Data window, byte, half or word access
// [RULE10] Type 0 stays on current bus
// [RULE11] Type 1 goes downstream by bus number
// [RULE12] Bridge converts or forwards Type 1 cycles
// [RULE13] Device number picks one IDSEL line; the decode gives devices above 15 none
// [RULE14] Targets hold 256 bytes configuration space
// [RULE15] Slots map to devices 4,9,10,11,13
// [RULE16] On-board functions follow fixed device map
// [RULE17] Targets expose vendor and device identifiers
// [RULE18] 32-bit multiplexed bus, one clock phases
// [RULE19] Window runs config cycle only when enabled
// [RULE20] Narrow reads take lanes from address
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ns
module pca_cfg_master (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output      logic [31:0] prdata,
   output      logic        pready,
   output      logic        pslverr,
   pca_bus_if.initiator     bus
);
   typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_DATA} pca_state_t;

   pca_state_t  st_q;
   logic [31:0] sel_q;
   logic [2:0]  cnt_q;
   logic        wr_q;
   logic [31:0] wdata_q;
   logic [3:0]  be_n_q;
   logic        pready_q;
   logic        pslverr_q;
   logic [31:0] prdata_q;
   logic        frame_n_q;
   logic        irdy_n_q;
   logic [3:0]  cbe_n_q;
   logic [31:0] ad_o_q;
   logic        ad_oe_n_q;
   logic [pca_pkg::IDSEL_W-1:0] idsel_lines;

   // ==========================================================================
   // Helper decodes
   function automatic logic [3:0] read_lanes(input logic [1:0] low);
      case (low)
         2'h0:    read_lanes = 4'hf;
         2'h1:    read_lanes = 4'h2;
         2'h2:    read_lanes = 4'hc;
         default: read_lanes = 4'h8;
      endcase
   endfunction

   // Unpopulated locations on buses 0 and 2 are answered here with all ones and no error for Type 0 selectors, without a bus cycle
   function automatic logic board_ok(input logic [7:0] b, input logic [4:0] d, input logic [2:0] f);
      if (b == pca_pkg::BUS_LOCAL) begin
         board_ok = (d == pca_pkg::DEV_MEMCTL) || (d == pca_pkg::DEV_GFXBRG) ||
                    (d == pca_pkg::DEV_PCIBRG) ||
                    (d == pca_pkg::DEV_IOHUB && f <= pca_pkg::IOHUB_FN_MAX);  // [RULE16]
      end else if (b == pca_pkg::BUS_EXP) begin
         board_ok = (d == pca_pkg::DEV_NIC) || (d == pca_pkg::DEV_SLOT1) ||
                    (d == pca_pkg::DEV_SLOT2) || (d == pca_pkg::DEV_SLOT3) ||
                    (d == pca_pkg::DEV_SLOT4) || (d == pca_pkg::DEV_SLOT5);  // [RULE15] [RULE16]
      end else begin
         board_ok = 1'b1;
      end
   endfunction

   // ==========================================================================
   // Selector fields
   wire       cfg_en  = sel_q[pca_pkg::EN_BIT];  // [RULE1]
   wire [7:0] sel_bus = sel_q[pca_pkg::BUS_HI:pca_pkg::BUS_LO];  // [RULE4]
   wire [4:0] sel_dev = sel_q[pca_pkg::DEV_HI:pca_pkg::DEV_LO];  // [RULE5]
   wire [2:0] sel_fn  = sel_q[pca_pkg::FN_HI:pca_pkg::FN_LO];  // [RULE6]
   wire [5:0] sel_idx = sel_q[pca_pkg::IDX_HI:pca_pkg::IDX_LO];  // [RULE7]
   wire       type1   = (sel_q[1:0] == pca_pkg::TYPE1);  // [RULE8]

   pca_idsel_dec u_dec (
      .dev   (sel_dev),
      .idsel (idsel_lines)
   );

   // Type 0 carries IDSEL in the upper lines; Type 1 carries the bus number
   wire [31:0] addr_t0 = {idsel_lines, sel_fn, sel_idx, pca_pkg::TYPE0};  // [RULE10] [RULE13]
   wire [31:0] addr_t1 = {8'h00, sel_bus, sel_dev, sel_fn, sel_idx, pca_pkg::TYPE1};  // [RULE11]
   wire [31:0] addr_io = {20'h0_0000, pca_pkg::DATA_OFS[11:2], paddr[1:0]};
   wire [31:0] cfg_addr = type1 ? addr_t1 : addr_t0;

   // ==========================================================================
   // APB decode
   wire access   = psel && penable && !pready_q;
   wire hit_sel  = (paddr[11:2] == pca_pkg::SEL_OFS[11:2]);
   wire hit_dat  = (paddr[11:2] == pca_pkg::DATA_OFS[11:2]);
   wire take     = (st_q == ST_IDLE) && access;
   wire full_wr  = pwrite && (pstrb == pca_pkg::STRB_FULL);
   wire sel_wr   = take && hit_sel && full_wr;  // [RULE2]
   wire route_ok = !cfg_en || type1 || board_ok(sel_bus, sel_dev, sel_fn);
   wire start    = take && hit_dat && route_ok;
   wire refuse   = take && (!(hit_sel || hit_dat) || (hit_sel && pwrite && !full_wr));  // [RULE2]
   wire quick    = take && !start;
   wire got      = !bus.trdy_n;
   wire done     = (st_q == ST_DATA) && (got || cnt_q == pca_pkg::ABORT_CYCLES);
   wire [3:0] be = pwrite ? pstrb : read_lanes(paddr[1:0]);  // [RULE9] [RULE20]
   wire [3:0] cmd = cfg_en ? (pwrite ? pca_pkg::CMD_CFG_WR : pca_pkg::CMD_CFG_RD)
                           : (pwrite ? pca_pkg::CMD_IO_WR : pca_pkg::CMD_IO_RD);  // [RULE19]

   // ==========================================================================
   // Selector register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sel_q <= pca_pkg::SEL_RESET;
      end else if (sel_wr) begin
         sel_q <= pwdata & pca_pkg::SEL_WMASK;  // [RULE3]
      end
   end

   // ==========================================================================
   // APB answer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= pca_pkg::ZERO_WORD;
      end else if (quick) begin
         pready_q  <= 1'b1;
         pslverr_q <= refuse;
         if (pwrite || refuse) begin
            prdata_q <= pca_pkg::ZERO_WORD;
         end else if (hit_sel) begin
            prdata_q <= sel_q & pca_pkg::SEL_WMASK;  // [RULE3]
         end else begin
            prdata_q <= pca_pkg::ALL_ONES;
         end
      end else if (done) begin
         pready_q  <= 1'b1;
         pslverr_q <= 1'b0;
         // Master abort reads back all ones, as a missing target would
         prdata_q  <= (wr_q || !got) ? (wr_q ? pca_pkg::ZERO_WORD : pca_pkg::ALL_ONES) : bus.ad;
      end else begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
      end
   end

   // ==========================================================================
   // Bus sequencer: address phase, then one data phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q      <= ST_IDLE;
         cnt_q     <= 3'h0;
         wr_q      <= 1'b0;
         wdata_q   <= pca_pkg::ZERO_WORD;
         be_n_q    <= pca_pkg::CBE_IDLE;
         frame_n_q <= 1'b1;
         irdy_n_q  <= 1'b1;
         cbe_n_q   <= pca_pkg::CBE_IDLE;
         ad_o_q    <= pca_pkg::ZERO_WORD;
         ad_oe_n_q <= 1'b1;
      end else begin
         case (st_q)
            ST_IDLE: begin
               if (start) begin
                  st_q      <= ST_ADDR;
                  wr_q      <= pwrite;
                  wdata_q   <= pwdata;
                  be_n_q    <= ~be;
                  frame_n_q <= 1'b0;
                  cbe_n_q   <= cmd;
                  ad_o_q    <= cfg_en ? cfg_addr : addr_io;  // [RULE18] [RULE19]
                  ad_oe_n_q <= 1'b0;
               end
            end
            ST_ADDR: begin
               st_q      <= ST_DATA;
               cnt_q     <= 3'h0;
               frame_n_q <= 1'b1;
               irdy_n_q  <= 1'b0;
               cbe_n_q   <= be_n_q;  // [RULE20]
               ad_o_q    <= wdata_q;
               ad_oe_n_q <= !wr_q;
            end
            ST_DATA: begin
               if (done) begin
                  st_q      <= ST_IDLE;
                  irdy_n_q  <= 1'b1;
                  cbe_n_q   <= pca_pkg::CBE_IDLE;
                  ad_oe_n_q <= 1'b1;
               end else begin
                  cnt_q <= cnt_q + 3'h1;
               end
            end
            default: begin
               st_q <= ST_IDLE;
            end
         endcase
      end
   end

   // ==========================================================================
   // Outputs
   assign prdata           = prdata_q;
   assign pready           = pready_q;
   assign pslverr          = pslverr_q;
   assign bus.frame_n      = frame_n_q;
   assign bus.irdy_n       = irdy_n_q;
   assign bus.cbe_n        = cbe_n_q;
   assign bus.init_ad_o    = ad_o_q;
   assign bus.init_ad_oe_n = ad_oe_n_q;
endmodule // pca_cfg_master

// ==== bench/pca_assertions.sv ====
// Concurrent checks on the configuration bus joining host and target
`timescale 1ns/1ns
module pca_assertions (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        frame_n,
   input wire logic        irdy_n,
   input wire logic [3:0]  cbe_n,
   input wire logic [31:0] init_ad_o,
   input wire logic        init_ad_oe_n,
   input wire logic        devsel_n,
   input wire logic        trdy_n,
   input wire logic [31:0] tgt_ad_o,
   input wire logic        tgt_ad_oe_n,
   input wire logic [31:0] ad
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // ==========================================================================
   // Phases
   sequence s_addr_rd;
      !frame_n && cbe_n == pca_pkg::CMD_CFG_RD;
   endsequence
   sequence s_claim;
      !devsel_n && !trdy_n;
   endsequence

   property p_frame_single;
      !frame_n |=> frame_n;
   endproperty
   a_frame_single: assert property (p_frame_single) else $error("frame low longer than one cycle");

   property p_addr_cmd;
      !frame_n |-> !init_ad_oe_n && cbe_n inside {4'h2, 4'h3, 4'ha, 4'hb};
   endproperty
   a_addr_cmd: assert property (p_addr_cmd) else $error("address phase without valid command");

   property p_data_phase;
      !frame_n |=> !irdy_n;
   endproperty
   a_data_phase: assert property (p_data_phase) else $error("no data phase after address");

   property p_idsel_onehot;
      (!frame_n && cbe_n[3:1] == 3'h5 && ad[1:0] == 2'h0) |-> $onehot0(ad[31:11]);
   endproperty
   a_idsel_onehot: assert property (p_idsel_onehot) else $error("more than one select line high");

   property p_claim_after_addr;
      !devsel_n |-> $past(!frame_n);
   endproperty
   a_claim_after_addr: assert property (p_claim_after_addr) else $error("claim not after address phase");

   property p_devsel_trdy;
      devsel_n == trdy_n;
   endproperty
   a_devsel_trdy: assert property (p_devsel_trdy) else $error("select and ready split");

   property p_claim_single;
      s_claim |=> devsel_n && trdy_n;
   endproperty
   a_claim_single: assert property (p_claim_single) else $error("claim held too long");

   property p_read_return;
      s_addr_rd ##1 s_claim |-> !tgt_ad_oe_n && init_ad_oe_n;
   endproperty
   a_read_return: assert property (p_read_return) else $error("read data not driven by target");

   property p_write_drive;
      (!frame_n && cbe_n == pca_pkg::CMD_CFG_WR) |=> !init_ad_oe_n && tgt_ad_oe_n;
   endproperty
   a_write_drive: assert property (p_write_drive) else $error("write data not driven by host");

   property p_no_clash;
      !(!init_ad_oe_n && !tgt_ad_oe_n);
   endproperty
   a_no_clash: assert property (p_no_clash) else $error("both ends drive the data lines");

   property p_end_bound;
      !frame_n |-> ##[2:8] irdy_n;
   endproperty
   a_end_bound: assert property (p_end_bound) else $error("transaction not ended in time");

   property p_idle_gap;
      $rose(irdy_n) |-> frame_n;
   endproperty
   a_idle_gap: assert property (p_idle_gap) else $error("no idle cycle between transactions");
endmodule // pca_assertions

// ==== bench/testbench.sv ====
// Self-checking bench: APB host end facing the configuration target
`timescale 1ns/1ns
module testbench;
   typedef struct packed {
      logic [7:0] bus;
      logic [4:0] dev;
      logic [2:0] fn;
      logic       ok;
   } pca_map_t;

   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [3:0]  pstrb;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        cfg_wr_stb;
   logic [5:0]  cfg_index;
   logic [31:0] last_addr;
   logic [3:0]  last_cmd;
   logic [31:0] rd;
   logic [31:0] exp_a;
   logic        err;
   int          n_mismatch;
   int          comparisons;
   int          n_frame = 0;
   int          n_wr = 0;
   int          f0;
   pca_map_t    map_tab [13] = '{{8'h02, 5'h04, 3'h0, 1'b1}, {8'h02, 5'h09, 3'h0, 1'b1},
                                 {8'h02, 5'h0a, 3'h0, 1'b1}, {8'h02, 5'h0b, 3'h0, 1'b1},
                                 {8'h02, 5'h0d, 3'h0, 1'b1}, {8'h02, 5'h05, 3'h0, 1'b0},
                                 {8'h02, 5'h08, 3'h0, 1'b1}, {8'h00, 5'h00, 3'h0, 1'b1},
                                 {8'h00, 5'h01, 3'h0, 1'b1}, {8'h00, 5'h1e, 3'h0, 1'b1},
                                 {8'h00, 5'h1f, 3'h5, 1'b1}, {8'h00, 5'h1f, 3'h6, 1'b0},
                                 {8'h00, 5'h02, 3'h0, 1'b0}};

   // ==========================================================================
   // Structure
   pca_bus_if pca_bus_if_inst ();

   pca_cfg_master pca_cfg_master_inst (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .bus(pca_bus_if_inst)
   );

   pca_cfg_target pca_cfg_target_inst (
      .pclk(pclk), .presetn(presetn), .bus(pca_bus_if_inst), .cfg_wr_stb(cfg_wr_stb), .cfg_index(cfg_index)
   );

   pca_assertions pca_assertions_inst (
      .pclk(pclk), .presetn(presetn), .frame_n(pca_bus_if_inst.frame_n), .irdy_n(pca_bus_if_inst.irdy_n),
      .cbe_n(pca_bus_if_inst.cbe_n), .init_ad_o(pca_bus_if_inst.init_ad_o),
      .init_ad_oe_n(pca_bus_if_inst.init_ad_oe_n), .devsel_n(pca_bus_if_inst.devsel_n),
      .trdy_n(pca_bus_if_inst.trdy_n), .tgt_ad_o(pca_bus_if_inst.tgt_ad_o),
      .tgt_ad_oe_n(pca_bus_if_inst.tgt_ad_oe_n), .ad(pca_bus_if_inst.ad)
   );

   always #10 pclk = ~pclk;

   // Sampled mid-cycle so the edge's own updates have landed
   always @(negedge pclk) begin
      if (presetn === 1'b1 && pca_bus_if_inst.frame_n === 1'b0) begin
         n_frame <= n_frame + 1;
         last_addr <= pca_bus_if_inst.ad;
         last_cmd <= pca_bus_if_inst.cbe_n;
      end
      if (cfg_wr_stb === 1'b1) begin
         n_wr <= n_wr + 1;
      end
   end

   // ==========================================================================
   // Tasks
   task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chk_flag(input string what, input logic exp, input logic got);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %b seen %b", what, exp, got);
      end
   endtask

   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, input logic [3:0] st);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      pstrb <= st;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      // Answer is taken at the rising edge that sees pready high, then released
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 40);
      if (pready !== 1'b1) begin
         n_mismatch++;
         $display("BAD pready expected 1 seen %b", pready);
         complete_run();
      end else begin
         rd = prdata;
         err = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask

   task automatic sel_w(input logic [31:0] v);
      apb(1'b1, 12'hcf8, v, 4'hf);
   endtask

   task automatic rd_at(input logic [11:0] a);
      apb(1'b0, a, 32'h0000_0000, 4'h0);
   endtask

   // ==========================================================================
   // Sequence
   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      pstrb = 4'h0;
      n_mismatch = 0;
      comparisons = 0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      rd_at(12'hcf8);
      chk_word("sel reset", 32'h0000_0000, rd);
      sel_w(32'hffff_ffff);
      rd_at(12'hcf8);
      chk_word("sel reserved", 32'h80ff_ffff, rd);
      apb(1'b1, 12'hcf8, 32'h0000_2000, 4'h3);
      chk_flag("sel narrow err", 1'b1, err);
      rd_at(12'hcf8);
      chk_word("sel kept", 32'h80ff_ffff, rd);
      rd_at(12'h100);
      chk_flag("unmapped err", 1'b1, err);
      chk_word("unmapped data", 32'h0000_0000, rd);
      // Enable clear: plain I/O cycle that nobody claims
      sel_w(32'h0002_2014);
      rd_at(12'hcfd);
      chk_word("io data", 32'hffff_ffff, rd);
      chk_word("io addr", 32'h0000_0cfd, last_addr);
      chk_word("io cmd", {28'h0, pca_pkg::CMD_IO_RD}, {28'h0, last_cmd});
      sel_w(32'h8002_2014);
      f0 = n_wr;
      apb(1'b1, 12'hcfc, 32'ha5a5_5a5a, 4'hf);
      apb(1'b1, 12'hcfd, 32'h0000_3c00, 4'h2);
      chk_flag("write strobes", 1'b1, n_wr == f0 + 2);
      rd_at(12'hcfc);
      chk_word("cfg data", 32'ha5a5_3c5a, rd);
      chk_flag("cfg err", 1'b0, err);
      chk_word("cfg addr", 32'h0010_0014, last_addr);
      chk_word("cfg index", 32'h0000_0005, {26'h0, cfg_index});
      chk_word("cfg cmd", {28'h0, pca_pkg::CMD_CFG_RD}, {28'h0, last_cmd});
      rd_at(12'hcfe);
      chk_word("half read", 32'ha5a5_0000, rd & 32'hffff_0000);
      // Type 1 to the bus behind the bridge path, then to a bus nobody serves
      sel_w(32'h8002_4015);
      rd_at(12'hcfc);
      chk_word("type1 data", 32'ha5a5_3c5a, rd);
      chk_word("type1 addr", 32'h0002_4015, last_addr);
      sel_w(32'h8003_4015);
      rd_at(12'hcfc);
      chk_word("type1 far bus", 32'hffff_ffff, rd);
      sel_w(32'h8002_2000);
      apb(1'b1, 12'hcfc, 32'h0000_0000, 4'hf);
      rd_at(12'hcfc);
      chk_word("id word", {pca_pkg::DEVICE_DFLT, pca_pkg::VENDOR_DFLT}, rd);
      foreach (map_tab[i]) begin
         sel_w({1'b1, 7'h00, map_tab[i].bus, map_tab[i].dev, map_tab[i].fn, 8'h00});
         f0 = n_frame;
         rd_at(12'hcfc);
         chk_flag("map cycle", map_tab[i].ok, n_frame == f0 + 1);
         exp_a = (map_tab[i].bus == 8'h02 && map_tab[i].dev == 5'h04) ? 32'h5678_1234 : 32'hffff_ffff;
         chk_word("map data", exp_a, rd);
         exp_a = {21'h0, map_tab[i].fn, 8'h00};
         if (map_tab[i].dev < 5'h10) begin
            exp_a[16 + map_tab[i].dev] = 1'b1;
         end
         if (map_tab[i].ok) begin
            chk_word("map addr", exp_a, last_addr);
         end
      end
      // Second reset in mid-run
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rd_at(12'hcf8);
      chk_word("sel rereset", 32'h0000_0000, rd);
      complete_run();
   end
endmodule // testbench
